// ==== logic/nvmac_top.sv ====
// nvm access control: register file, unlock guard, read and timed
// erase/write sequencing for the data eeprom and the program flash path.
// assumes the core drives the register port synchronously to ref_clk and
// that the flash array itself sits outside, driven by the pm_* outputs.
module nvmac_top
   import nvmac_pkg::*;
#(
   parameter int unsigned EE_ERASE_CYCLES = EE_ERASE_CYC,
   parameter int unsigned EE_WRITE_CYCLES = EE_WRITE_CYC,
   parameter int unsigned PM_OP_CYCLES    = PM_OP_CYC
)
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        external_pin_reset,
   input  wire logic        watchdog_timer_reset,
   input  wire logic [3:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   output logic             cpu_stall,
   output logic             eeprom_busy,
   output logic             pm_start,
   output logic             pm_erase,
   output logic             pm_cfg_sel,
   output logic      [21:0] pm_addr
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   nvmac_state_t  state_q;
   nvmac_unlock_t unlock_q;

   logic [7:0] table_pointer_u_q;
   logic [7:0] table_pointer_h_q;
   logic [7:0] table_pointer_l_q;
   logic [7:0] table_latch_q;
   logic [7:0] interrupt_control_q;
   logic [7:0] peripheral_int_priority_2_q;
   logic [7:0] peripheral_int_flags_2_q;
   logic [7:0] peripheral_int_enables_2_q;
   logic [7:0] eeprom_data_byte_q;
   logic [7:0] eeprom_address_low_l_q;
   logic [EEH_BITS-1:0] eeprom_address_low_h_q;

   logic msel_q;
   logic configuration_select_q;
   logic free_q;
   logic write_error_flag_q;
   logic write_permit_q;
   logic wr_q;
   logic rd_q;

   logic [EE_AW-1:0] op_addr_q;
   logic [7:0]       op_data_q;
   logic [7:0]       rdata_q;
   logic             pm_start_q;
   logic             pm_erase_q;
   logic             pm_cfg_q;
   logic [21:0]      pm_addr_q;

   logic             warm_rst;
   logic             wr_ctl;
   logic             wr_go;
   logic             rd_go;
   logic             go_ee;
   logic             tmr_start;
   logic [TMR_W-1:0] tmr_load;
   logic             tmr_done;
   logic             mem_we;
   logic [7:0]       mem_wdata;
   logic [7:0]       mem_rdata;
   logic             write_done;

   // decodes the array that the select bits point at
   function automatic logic targets_eeprom(input logic configuration_select, input logic msel);
      targets_eeprom = !configuration_select && !msel;
   endfunction

   function automatic logic wr_hit(input logic [3:0] idx);
      wr_hit = sfr_wr && (sfr_addr == idx);
   endfunction

   // -----------------------------------------------------------------
   // request decode
   // -----------------------------------------------------------------
   // pin and watchdog resets abort the running operation and clear the unlock state and the free, permit, wr and rd bits
   assign warm_rst = external_pin_reset || watchdog_timer_reset;
   assign wr_ctl   = wr_hit(SFR_CONTROL) && !warm_rst;

   // a write start needs permit and the unlock pair as the last two writes
   assign wr_go = wr_ctl && sfr_wdata[CTL_WR] && write_permit_q
                  && (unlock_q == UL_ARMED) && (state_q == ST_IDLE);

   // reads only from the eeprom, never from program memory
   assign rd_go = wr_ctl && sfr_wdata[CTL_RD] && !wr_go && (state_q == ST_IDLE)
                  && targets_eeprom(sfr_wdata[CTL_CONFIGURATION_SELECT], sfr_wdata[CTL_MSEL]);

   // target taken from the written value: the same write also loads the select bits
   assign go_ee = targets_eeprom(sfr_wdata[CTL_CONFIGURATION_SELECT], sfr_wdata[CTL_MSEL]);

   // -----------------------------------------------------------------
   // unlock sequence tracker
   // -----------------------------------------------------------------
   // any other register write between the keys disarms the sequence
   always_ff @(posedge ref_clk) begin
      if (sys_rst || warm_rst) begin
         unlock_q <= UL_IDLE;
      end else if (sfr_wr) begin
         if (sfr_addr == SFR_UNLOCK && sfr_wdata == UNLOCK_KEY1) begin
            unlock_q <= UL_KEY1;
         end else if (sfr_addr == SFR_UNLOCK && sfr_wdata == UNLOCK_KEY2
                      && unlock_q == UL_KEY1) begin
            unlock_q <= UL_ARMED;
         end else begin
            unlock_q <= UL_IDLE;
         end
      end
   end

   // -----------------------------------------------------------------
   // operation sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst || warm_rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (wr_go) begin
                  state_q <= go_ee ? ST_EE_ERASE : ST_PM_OP;
               end else if (rd_go) begin
                  state_q <= ST_READ;
               end
            end
            ST_READ: begin
               state_q <= ST_IDLE;
            end
            ST_EE_ERASE: begin
               if (tmr_done) begin
                  state_q <= ST_EE_WRITE;
               end
            end
            ST_EE_WRITE: begin
               if (tmr_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_PM_OP: begin
               if (tmr_done) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // latch address and data so later register writes cannot corrupt the op
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         op_addr_q <= '0;
         op_data_q <= BYTE_RESET;
      end else if (wr_go) begin
         op_addr_q <= {eeprom_address_low_h_q, eeprom_address_low_l_q};
         op_data_q <= eeprom_data_byte_q;
      end
   end

   // -----------------------------------------------------------------
   // programming timer and array
   // -----------------------------------------------------------------
   assign tmr_start = wr_go || (state_q == ST_EE_ERASE && tmr_done);
   always_comb begin
      if (state_q == ST_EE_ERASE) begin
         tmr_load = TMR_W'(EE_WRITE_CYCLES);
      end else if (go_ee) begin
         tmr_load = TMR_W'(EE_ERASE_CYCLES);
      end else begin
         tmr_load = TMR_W'(PM_OP_CYCLES);
      end
   end

   nvmac_prog_timer u_timer (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .start   (tmr_start),
      .load    (tmr_load),
      .abort   (warm_rst),
      .busy    (),
      .done    (tmr_done)
   );

   // the erase pass writes the blank value, the second pass the new byte
   assign mem_we    = tmr_done && (state_q == ST_EE_ERASE || state_q == ST_EE_WRITE);
   assign mem_wdata = (state_q == ST_EE_ERASE) ? ERASED_BYTE : op_data_q;

   nvmac_eeprom_mem u_mem (
      .ref_clk (ref_clk),
      .we      (mem_we),
      .waddr   (op_addr_q),
      .wdata   (mem_wdata),
      .re      (rd_go),
      .raddr   ({eeprom_address_low_h_q, eeprom_address_low_l_q}),
      .rdata_q (mem_rdata)
   );

   assign write_done = tmr_done && (state_q == ST_EE_WRITE || state_q == ST_PM_OP);

   // -----------------------------------------------------------------
   // control register
   // -----------------------------------------------------------------
   // start bits are set-only from software; hardware clears them
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         msel_q <= 1'b0;
         configuration_select_q <= 1'b0;
         free_q <= 1'b0;
         write_permit_q <= 1'b0;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
      end else if (warm_rst) begin
         free_q <= 1'b0;
         write_permit_q <= 1'b0;
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
      end else begin
         if (write_done) begin
            wr_q   <= 1'b0;
            free_q <= 1'b0;
         end
         if (state_q == ST_READ) begin
            rd_q <= 1'b0;
         end
         if (wr_ctl) begin
            msel_q <= sfr_wdata[CTL_MSEL];
            configuration_select_q <= sfr_wdata[CTL_CONFIGURATION_SELECT];
            free_q <= sfr_wdata[CTL_FREE];
            write_permit_q <= sfr_wdata[CTL_WRITE_PERMIT];
         end
         if (wr_go) begin
            wr_q <= 1'b1;
         end
         if (rd_go) begin
            rd_q <= 1'b1;
         end
      end
   end

   // error flag survives pin and watchdog resets so software can retry
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         write_error_flag_q <= 1'b0;
      end else if (warm_rst) begin
         write_error_flag_q <= write_error_flag_q;
      end else if (wr_go) begin
         write_error_flag_q <= 1'b1;
      end else if (write_done) begin
         write_error_flag_q <= 1'b0;
      end else if (wr_ctl) begin
         write_error_flag_q <= sfr_wdata[CTL_WRITE_ERROR_FLAG];
      end
   end

   // -----------------------------------------------------------------
   // interrupt flag register
   // -----------------------------------------------------------------
   // the hardware set is applied last so it wins over a clear
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         peripheral_int_flags_2_q <= BYTE_RESET;
      end else begin
         if (wr_hit(SFR_PERIPHERAL_INT_FLAGS_2)) begin
            peripheral_int_flags_2_q <= sfr_wdata;
         end
         if (write_done) begin
            peripheral_int_flags_2_q[PERIPHERAL_INT_FLAGS_2_EEPROM_WRITE_DONE_FLAG] <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // data and address registers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         eeprom_data_byte_q <= BYTE_RESET;
      end else if (state_q == ST_READ) begin
         eeprom_data_byte_q <= mem_rdata;
      end else if (wr_hit(SFR_EEPROM_DATA_BYTE)) begin
         eeprom_data_byte_q <= sfr_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         eeprom_address_low_l_q <= BYTE_RESET;
         eeprom_address_low_h_q <= '0;
      end else begin
         if (wr_hit(SFR_EEPROM_ADDRESS_LOW_L)) begin
            eeprom_address_low_l_q <= sfr_wdata;
         end
         if (wr_hit(SFR_EEPROM_ADDRESS_LOW_H)) begin
            eeprom_address_low_h_q <= sfr_wdata[EEH_BITS-1:0];
         end
      end
   end

   // plain storage registers; only the table pointers are used, to form the flash address
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         table_pointer_u_q <= BYTE_RESET;
         table_pointer_h_q <= BYTE_RESET;
         table_pointer_l_q <= BYTE_RESET;
         table_latch_q   <= BYTE_RESET;
         interrupt_control_q   <= BYTE_RESET;
         peripheral_int_priority_2_q     <= BYTE_RESET;
         peripheral_int_enables_2_q     <= BYTE_RESET;
      end else if (sfr_wr) begin
         unique case (sfr_addr)
            SFR_TABLE_POINTER_U: table_pointer_u_q <= sfr_wdata;
            SFR_TABLE_POINTER_H: table_pointer_h_q <= sfr_wdata;
            SFR_TABLE_POINTER_L: table_pointer_l_q <= sfr_wdata;
            SFR_TABLE_LATCH:   table_latch_q   <= sfr_wdata;
            SFR_INTERRUPT_CONTROL:   interrupt_control_q   <= sfr_wdata;
            SFR_PERIPHERAL_INT_PRIORITY_2:     peripheral_int_priority_2_q     <= sfr_wdata;
            SFR_PERIPHERAL_INT_ENABLES_2:     peripheral_int_enables_2_q     <= sfr_wdata;
            default:      ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // register read port
   // -----------------------------------------------------------------
   // unlock register and unmapped indices read as zero
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdata_q <= BYTE_RESET;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            SFR_TABLE_POINTER_U: rdata_q <= table_pointer_u_q;
            SFR_TABLE_POINTER_H: rdata_q <= table_pointer_h_q;
            SFR_TABLE_POINTER_L: rdata_q <= table_pointer_l_q;
            SFR_TABLE_LATCH:   rdata_q <= table_latch_q;
            SFR_INTERRUPT_CONTROL:   rdata_q <= interrupt_control_q;
            SFR_UNLOCK:   rdata_q <= BYTE_RESET;
            SFR_CONTROL:  rdata_q <= {msel_q, configuration_select_q, 1'b0, free_q,
                                      write_error_flag_q, write_permit_q, wr_q, rd_q};
            SFR_PERIPHERAL_INT_PRIORITY_2:     rdata_q <= peripheral_int_priority_2_q;
            SFR_PERIPHERAL_INT_FLAGS_2:     rdata_q <= peripheral_int_flags_2_q;
            SFR_PERIPHERAL_INT_ENABLES_2:     rdata_q <= peripheral_int_enables_2_q;
            SFR_EEPROM_DATA_BYTE:   rdata_q <= eeprom_data_byte_q;
            SFR_EEPROM_ADDRESS_LOW_L:  rdata_q <= eeprom_address_low_l_q;
            SFR_EEPROM_ADDRESS_LOW_H:  rdata_q <= {{(8-EEH_BITS){1'b0}}, eeprom_address_low_h_q};
            default:      rdata_q <= BYTE_RESET;
         endcase
      end
   end

   assign sfr_rdata = rdata_q;

   // -----------------------------------------------------------------
   // program flash request path
   // -----------------------------------------------------------------
   // block erase and target are frozen at the start for the whole op
   always_ff @(posedge ref_clk) begin
      if (sys_rst || warm_rst) begin
         pm_start_q <= 1'b0;
         pm_erase_q <= 1'b0;
         pm_cfg_q   <= 1'b0;
         pm_addr_q  <= '0;
      end else begin
         pm_start_q <= wr_go && !go_ee;
         if (wr_go && !go_ee) begin
            pm_erase_q <= free_q;
            pm_cfg_q   <= sfr_wdata[CTL_CONFIGURATION_SELECT];
            pm_addr_q  <= {table_pointer_u_q[5:0], table_pointer_h_q, table_pointer_l_q};
         end
      end
   end

   assign pm_start    = pm_start_q;
   assign pm_erase    = pm_erase_q;
   assign pm_cfg_sel  = pm_cfg_q;
   assign pm_addr     = pm_addr_q;
   // core is held while the flash is programmed; eeprom writes run alongside
   assign cpu_stall   = (state_q == ST_PM_OP);
   assign eeprom_busy = (state_q == ST_EE_ERASE) || (state_q == ST_EE_WRITE);

endmodule

// ==== logic/nvmac_pkg.sv ====
// nvm access control: shared constants for the register port, control
// bit layout, reset values and programming times.
// assumes a single 10 MHz clock and a byte-wide register port of the core.
package nvmac_pkg;

   // -----------------------------------------------------------------
   // clock and programming times
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned EE_ERASE_NS   = 2_000_000;  // plain default, no figure given
   localparam int unsigned EE_WRITE_NS   = 2_000_000;  // plain default, no figure given
   localparam int unsigned PM_OP_NS      = 2_000_000;  // plain default, no figure given
   // least times round up to whole cycles
   localparam int unsigned EE_ERASE_CYC  = (EE_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned EE_WRITE_CYC  = (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PM_OP_CYC     = (PM_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W         = 16;

   // -----------------------------------------------------------------
   // register port indices
   // -----------------------------------------------------------------
   localparam logic [3:0] SFR_TABLE_POINTER_U = 4'h0;
   localparam logic [3:0] SFR_TABLE_POINTER_H = 4'h1;
   localparam logic [3:0] SFR_TABLE_POINTER_L = 4'h2;
   localparam logic [3:0] SFR_TABLE_LATCH   = 4'h3;
   localparam logic [3:0] SFR_INTERRUPT_CONTROL   = 4'h4;
   localparam logic [3:0] SFR_UNLOCK   = 4'h5;
   localparam logic [3:0] SFR_CONTROL  = 4'h6;
   localparam logic [3:0] SFR_PERIPHERAL_INT_PRIORITY_2     = 4'h7;
   localparam logic [3:0] SFR_PERIPHERAL_INT_FLAGS_2     = 4'h8;
   localparam logic [3:0] SFR_PERIPHERAL_INT_ENABLES_2     = 4'h9;
   localparam logic [3:0] SFR_EEPROM_DATA_BYTE   = 4'hA;
   localparam logic [3:0] SFR_EEPROM_ADDRESS_LOW_L  = 4'hB;
   localparam logic [3:0] SFR_EEPROM_ADDRESS_LOW_H  = 4'hC;

   // -----------------------------------------------------------------
   // control register bit positions
   // -----------------------------------------------------------------
   localparam int unsigned CTL_MSEL  = 7;
   localparam int unsigned CTL_CONFIGURATION_SELECT  = 6;
   localparam int unsigned CTL_FREE  = 4;
   localparam int unsigned CTL_WRITE_ERROR_FLAG = 3;
   localparam int unsigned CTL_WRITE_PERMIT  = 2;
   localparam int unsigned CTL_WR    = 1;
   localparam int unsigned CTL_RD    = 0;
   localparam int unsigned PERIPHERAL_INT_FLAGS_2_EEPROM_WRITE_DONE_FLAG = 4;

   // -----------------------------------------------------------------
   // values and sizes
   // -----------------------------------------------------------------
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [7:0] BYTE_RESET  = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int unsigned EE_AW      = 10;   // 1024 bytes
   localparam int unsigned EEH_BITS   = 2;    // high address bits added

   typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} nvmac_unlock_t;
   typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EE_ERASE, ST_EE_WRITE, ST_PM_OP} nvmac_state_t;

endpackage

// ==== logic/nvmac_eeprom_mem.sv ====
// nvm access control: 1024 x 8 data eeprom array model with registered read.
// assumes one write or one read per cycle, issued by the control block.
module nvmac_eeprom_mem
   import nvmac_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              we,
   input  wire logic [EE_AW-1:0]  waddr,
   input  wire logic [7:0]        wdata,
   input  wire logic              re,
   input  wire logic [EE_AW-1:0]  raddr,
   output logic      [7:0]        rdata_q
);

   logic [7:0] mem [0:(1<<EE_AW)-1];

   // -----------------------------------------------------------------
   // array write
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // read data held until the next read
   always_ff @(posedge ref_clk) begin
      if (re) begin
         rdata_q <= mem[raddr];
      end
   end

endmodule

// ==== logic/nvmac_prog_timer.sv ====
// nvm access control: on-chip programming timer.
// assumes start is a one-cycle pulse; done pulses after load cycles.
module nvmac_prog_timer
   import nvmac_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   input  wire logic              start,
   input  wire logic [TMR_W-1:0]  load,
   input  wire logic              abort,
   output logic                   busy,
   output logic                   done
);

   logic [TMR_W-1:0] cnt_q;
   localparam logic [TMR_W-1:0] CNT_LAST = TMR_W'(1);

   // -----------------------------------------------------------------
   // countdown; a restart in the done cycle reloads the count
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst || abort) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= load;
      end else if (busy) begin
         cnt_q <= cnt_q - CNT_LAST;
      end
   end

   assign busy = (cnt_q != '0);
   assign done = (cnt_q == CNT_LAST) && !abort;

endmodule

// ==== dv/nvmac_properties.sv ====
// nvm access control: concurrent checks on the top ports.
// assumes bind onto nvmac_top with a flash op time of 9 to 11 cycles and eeprom passes of 8 cycles or more together.
module nvmac_properties
   import nvmac_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       sys_rst,
   input wire logic       external_pin_reset,
   input wire logic       watchdog_timer_reset,
   input wire logic [3:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic       cpu_stall,
   input wire logic       eeprom_busy,
   input wire logic       pm_start
);
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------------
   // properties
   // -----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // software write that asks for write-start
   wire go = sfr_wr && sfr_addr == SFR_CONTROL && sfr_wdata[CTL_WR];
   a_unlock_reads_zero: assert property (sfr_rd && sfr_addr == SFR_UNLOCK |=> !sfr_rdata)
      else $error("unlock index read not zero");
   a_pm_needs_go: assert property (pm_start |-> $past(go))
      else $error("flash start without write-start");
   a_ee_needs_go: assert property ($rose(eeprom_busy) |-> $past(go))
      else $error("eeprom start without write-start");
   a_stall_holds: assert property ($rose(cpu_stall) |-> cpu_stall[*8])
      else $error("stall too short");
   a_stall_ends: assert property ($rose(cpu_stall) |-> ##[9:11] !cpu_stall)
      else $error("stall not ended by timer");
   a_busy_holds: assert property ($rose(eeprom_busy) |-> eeprom_busy[*8])
      else $error("eeprom pass too short");
   a_reset_aborts: assert property (external_pin_reset || watchdog_timer_reset
      |=> !cpu_stall && !eeprom_busy)
      else $error("op survived reset");
   // the written select bits, not the old ones, pick the array that runs
   a_one_target: assert property ($rose(cpu_stall) || $rose(eeprom_busy) |->
      cpu_stall == $past(sfr_wdata[CTL_MSEL] || sfr_wdata[CTL_CONFIGURATION_SELECT]))
      else $error("op started on the wrong target");
   a_start_pulse: assert property (pm_start |=> !pm_start)
      else $error("start not a pulse");
endmodule
bind nvmac_top nvmac_properties u_props (.*);

// ==== dv/nvmac_core_model.sv ====
// nvm access control: core model driving the register port.
// assumes the bench calls one task at a time.
module nvmac_core_model
   import nvmac_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] sfr_rdata,
   output logic      [3:0] sfr_addr,
   output logic            sfr_wr,
   output logic            sfr_rd,
   output logic      [7:0] sfr_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------------
   // bus tasks
   // -----------------------------------------------------------------
   initial begin
      {sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
   end
   // released data shows the inverse so stale bytes never pass
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk) #1;
      {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
      @(posedge ref_clk) #1;
      {sfr_wdata, sfr_wr} = {~d, 1'b0};
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge ref_clk) #1;
      {sfr_addr, sfr_rd} = {a, 1'b1};
      @(posedge ref_clk) #1;
      sfr_rd = 0;
      @(posedge ref_clk) #1;
      q = sfr_rdata;
   endtask
   // key pair, must sit right before write-start
   task automatic unlock();
      wr(SFR_UNLOCK, UNLOCK_KEY1);
      wr(SFR_UNLOCK, UNLOCK_KEY2);
   endtask
endmodule

// ==== dv/nvm_access_control_test.sv ====
// nvm access control: self-checking bench against a reference model.
// assumes short op times 5/7/9 and the core model on the register port.
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module nvm_access_control_test
   import nvmac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------------
   // wiring and model state
   // -----------------------------------------------------------------
   logic ref_clk = 0, sys_rst = 1, pin_rst = 0, wd_rst = 0, er, cf;
   logic [7:0] q, sr, sd;
   logic [3:0] sa;
   logic sw, srd, st, eb, ps;
   logic [21:0] pa, pad;
   int err_count = 0, check_count = 0, cyc = 0, ps_n = 0, a, d;
   int mem[1024];
   always #50 ref_clk = ~ref_clk;
   nvmac_top #(.EE_ERASE_CYCLES(5), .EE_WRITE_CYCLES(7), .PM_OP_CYCLES(9)) dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .external_pin_reset(pin_rst),
      .watchdog_timer_reset(wd_rst), .sfr_addr(sa), .sfr_wr(sw), .sfr_rd(srd),
      .sfr_wdata(sd), .sfr_rdata(sr), .cpu_stall(st), .eeprom_busy(eb),
      .pm_start(ps), .pm_erase(er), .pm_cfg_sel(cf), .pm_addr(pad));
   nvmac_core_model core (.ref_clk(ref_clk), .sfr_rdata(sr), .sfr_addr(sa),
      .sfr_wr(sw), .sfr_rd(srd), .sfr_wdata(sd));
   // capture each flash start since it stands one cycle only
   always @(posedge ref_clk) if (ps === 1'b1) begin
      ps_n++;
      pa = pad;
   end
   // hang guard, far above the expected run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic idle();
      for (int i = 0; i < 100 && (eb !== 1'b0 || st !== 1'b0); i++) @(posedge ref_clk);
      #1;
      // an op that never ends is a failure, not a silent fall-through
      if (eb !== 1'b0 || st !== 1'b0) begin
         err_count++;
         results();
      end
   endtask
   task automatic ee_wr(input int ad, input int dt);
      core.wr(SFR_EEPROM_ADDRESS_LOW_L, 8'(ad));
      core.wr(SFR_EEPROM_ADDRESS_LOW_H, 8'(ad >> 8));
      core.wr(SFR_EEPROM_DATA_BYTE, 8'(dt));
      core.wr(SFR_CONTROL, 8'h04);
      core.unlock();
      core.wr(SFR_CONTROL, 8'h06);
      mem[ad] = dt;
   endtask
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      void'($urandom(46));
      repeat (16) @(posedge ref_clk);
      #1 sys_rst = 0;
      core.rd(SFR_CONTROL, q); `CHK(q, 8'h00)
      core.rd(SFR_UNLOCK, q); `CHK(q, 8'h00)
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         a = $urandom % 1024;
         d = $urandom % 256;
         ee_wr(a, d);
         `CHK({eb, st}, 2'b10)
         core.rd(SFR_CONTROL, q); `CHK(q, 8'h0E)
         core.wr(SFR_CONTROL, 8'h0C);
         core.rd(SFR_CONTROL, q); `CHK(q, 8'h0E)
         idle();
         core.rd(SFR_CONTROL, q); `CHK(q, 8'h04)
         core.rd(SFR_PERIPHERAL_INT_FLAGS_2, q); `CHK(q[PERIPHERAL_INT_FLAGS_2_EEPROM_WRITE_DONE_FLAG], 1'b1)
         core.wr(SFR_PERIPHERAL_INT_FLAGS_2, 8'h00);
         core.rd(SFR_PERIPHERAL_INT_FLAGS_2, q); `CHK(q, 8'h00)
         core.wr(SFR_CONTROL, 8'h01);
         repeat (3) @(posedge ref_clk);
         core.rd(SFR_EEPROM_DATA_BYTE, q); `CHK(q, 8'(mem[a]))
      end
      $display("test eeprom done");
      // flash with no keys, eeprom with a write between keys and start, then eeprom with no permit after keys
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 8'h84 : ((i == 2) ? 0 : 4);
         core.wr(SFR_CONTROL, 8'(d));
         if (i > 0) core.unlock();
         if (i == 1) core.wr(SFR_EEPROM_DATA_BYTE, 8'h5A);
         core.wr(SFR_CONTROL, 8'(d | 2));
         core.rd(SFR_CONTROL, q); `CHK(q, 8'(d))
      end
      core.wr(SFR_CONTROL, 8'h81);
      core.rd(SFR_CONTROL, q); `CHK(q, 8'h80)
      $display("test refusal done");
      for (int k = 0; k < 2; k++) begin
         a = $urandom;
         core.wr(SFR_TABLE_POINTER_U, 8'(a >> 16));
         core.wr(SFR_TABLE_POINTER_H, 8'(a >> 8));
         core.wr(SFR_TABLE_POINTER_L, 8'(a));
         d = k ? 8'h44 : 8'h94;
         core.wr(SFR_CONTROL, 8'(d));
         core.unlock();
         core.wr(SFR_CONTROL, 8'(d | 2));
         `CHK({st, eb}, 2'b10)
         idle();
         `CHK(ps_n, k + 1)
         `CHK({er, cf}, {1'(k == 0), 1'(k)})
         `CHK(pa, 22'(a))
         core.rd(SFR_CONTROL, q); `CHK(q, 8'(k ? 8'h44 : 8'h84))
      end
      $display("test flash done");
      for (int k = 0; k < 2; k++) begin
         ee_wr(k, 8'h3C);
         repeat (8) @(posedge ref_clk);
         #1 {wd_rst, pin_rst} = k ? 2'b10 : 2'b01;
         @(posedge ref_clk) #1 {wd_rst, pin_rst} = 2'b00;
         `CHK(eb, 1'b0)
         core.rd(SFR_CONTROL, q); `CHK(q, 8'h08)
      end
      $display("test abort done");
      results();
   end
endmodule
